// >>> cct_pkg.sv
// constants shared by the channel code translate and bit force block
// Functional notes
// - Code translation runs the same way in connection mode and in message mode.
// - Bit 4 of an output channel's upper map entry picks voice (0) or data (1) coding.
// - Bits 3-2 of the upper map entry give the input law and bits 1-0 the output law.
// - Voice codes are 00 A-law, 01 mu-law, 10 A-law without even-bit inversion, 11 mu-law without magnitude inversion.
// - The A-law variant leaves bits 6, 4, 2 and 0 uninverted and is otherwise standard A-law.
// - The mu-law variant leaves magnitude bits 6 to 0 uninverted and is otherwise standard mu-law.
// - Data codes are 00 unchanged, 01 even bits inverted, 10 odd bits inverted, 11 all bits inverted.
// - Input and output laws are independent; differing laws are translated, equal laws pass as is.
// - One voice/data bit per channel means voice and data laws are never mixed in a channel.
// - An input frame splits into four equal quadrants of 8, 16, 32 or 64 channels by rate.
// - Each stream's quadrant control register holds quadrant 3..0 codes in bits 11-9, 8-6, 5-3, 2-0.
// - Quadrant code 0xx passes data, 100/101 force the LSB to 0/1, 110/111 force the MSB to 0/1.
package cct_pkg;
   // register window
   localparam logic [13:0] CCT_QFORCE_BASE = 14'h0120;
   localparam logic [13:0] CCT_CMH_BASE = 14'h2000;
   localparam int CCT_NUM_STREAMS = 32;
   localparam int CCT_QFORCE_W = 12;
   localparam logic [11:0] CCT_QFORCE_RESET = 12'h000;
   localparam logic [4:0] CCT_CMH_RESET = 5'h00;
   // upper map entry fields
   localparam int CCT_CMH_VD_BIT = 4;
   localparam int CCT_CMH_ICL_LSB = 2;
   localparam int CCT_CMH_OCL_LSB = 0;
   // quadrant code fields
   localparam int CCT_QF_FIELD_W = 3;
   localparam int CCT_QF_EN_BIT = 2;
   localparam int CCT_QF_MSB_BIT = 1;
   localparam int CCT_QF_VAL_BIT = 0;
   localparam int CCT_Q_BASE_SHIFT = 3;
   // line code masks
   localparam logic [7:0] CCT_EVEN_MASK = 8'h55;
   localparam logic [7:0] CCT_ODD_MASK = 8'haa;
   localparam logic [7:0] CCT_ALL_MASK = 8'hff;
   localparam logic [7:0] CCT_MAG_MASK = 8'h7f;
   localparam logic [15:0] CCT_MU_BIAS = 16'h0084;
   localparam logic [15:0] CCT_LIN_MAX = 16'h7fff;
   localparam int CCT_FIFO_DEPTH = 4;

   typedef enum logic [1:0] {
      CCT_LAW_A,
      CCT_LAW_MU,
      CCT_LAW_A_NOABI,
      CCT_LAW_MU_NOMI
   } cct_law_t;
endpackage : cct_pkg

// >>> cct_top.sv
// code translate and quadrant bit force datapath with its fifo
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// small valid/ready fifo
// ----------------------------------------
module cct_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic s_valid,
   output logic s_ready,
   input wire logic [WIDTH-1:0] s_data,
   output logic m_valid,
   input wire logic m_ready,
   output logic [WIDTH-1:0] m_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;
   logic [AW:0] next_count;

   assign push = s_valid && s_ready;
   assign pop = m_valid && m_ready;
   assign m_data = mem[rd_ptr];

   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= '0;
         s_ready <= 1'b0;
         m_valid <= 1'b0;
      end else begin
         count <= next_count;
         // registered flags keep full and empty honest without a comb path
         s_ready <= (next_count != (AW+1)'(DEPTH));
         m_valid <= (next_count != '0);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= s_data;
      end
   end
endmodule : cct_fifo

// ----------------------------------------
// channel code translate and bit force
// ----------------------------------------
module cct_top
   import cct_pkg::*;
#(
   parameter int CH_W = 12,
   parameter int FIFO_DEPTH = CCT_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_b,
   // register access
   input wire logic reg_we,
   input wire logic reg_re,
   input wire logic [13:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   // input channel bytes from the serial side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [7:0] in_byte,
   input wire logic [4:0] in_stream,
   input wire logic [7:0] in_chan,
   input wire logic [1:0] in_rate,
   input wire logic [CH_W-1:0] in_out_chan,
   // translated output channel bytes
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] out_byte,
   output logic [CH_W-1:0] out_chan
);
   localparam int NUM_CH = 1 << CH_W;
   localparam int FW = CH_W + 8;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // rate 0..3 gives 8, 16, 32, 64 channels a quadrant
   function automatic logic [1:0] quadrant_of(input logic [7:0] ch, input logic [1:0] rate);
      logic [7:0] q;
      q = ch >> (CCT_Q_BASE_SHIFT + int'(rate));
      return q[1:0];
   endfunction : quadrant_of

   function automatic logic [7:0] data_mask(input logic [1:0] code);
      case (code)
         2'b00: return 8'h00;
         2'b01: return CCT_EVEN_MASK;
         2'b10: return CCT_ODD_MASK;
         default: return CCT_ALL_MASK;
      endcase
   endfunction : data_mask

   // variant codes differ from the standard ones only by an xor
   function automatic logic [7:0] variant_mask(input logic [1:0] law);
      case (cct_law_t'(law))
         CCT_LAW_A_NOABI: return CCT_EVEN_MASK;
         CCT_LAW_MU_NOMI: return CCT_MAG_MASK;
         default: return 8'h00;
      endcase
   endfunction : variant_mask

   // standard A-law line byte to 16-bit scaled magnitude
   function automatic logic [15:0] a_to_lin(input logic [7:0] b);
      logic [6:0] t;
      logic [15:0] v;
      t = b[6:0] ^ CCT_EVEN_MASK[6:0];
      if (t[6:4] == 3'd0) begin
         v = {11'd0, t[3:0], 1'b1};
      end else begin
         v = 16'({t[3:0], 1'b1} + 6'd32) << (t[6:4] - 3'd1);
      end
      return v << 3;
   endfunction : a_to_lin

   // standard mu-law line byte to 16-bit scaled magnitude
   function automatic logic [15:0] mu_to_lin(input logic [7:0] b);
      logic [6:0] t;
      logic [15:0] v;
      t = ~b[6:0];
      v = (16'({t[3:0], 3'b000}) + CCT_MU_BIAS) << t[6:4];
      return v - CCT_MU_BIAS;
   endfunction : mu_to_lin

   function automatic logic [6:0] lin_to_a(input logic [15:0] lin);
      logic [11:0] v;
      logic [2:0] e;
      logic [11:0] m;
      v = lin[14:3];
      e = 3'd0;
      for (int i = 1; i < 8; i++) begin
         if (v >= (12'd16 << i)) begin
            e = 3'(i);
         end
      end
      m = (e == 3'd0) ? (v >> 1) : (v >> e);
      return {e, m[3:0]} ^ CCT_EVEN_MASK[6:0];
   endfunction : lin_to_a

   function automatic logic [6:0] lin_to_mu(input logic [15:0] lin);
      logic [15:0] l;
      logic [2:0] e;
      logic [15:0] m;
      l = (lin > CCT_LIN_MAX - CCT_MU_BIAS) ? CCT_LIN_MAX : lin + CCT_MU_BIAS;
      e = 3'd0;
      for (int i = 1; i < 8; i++) begin
         if (l >= (16'h0080 << i)) begin
            e = 3'(i);
         end
      end
      // widen first: a 3-bit sum would wrap for the top three segments
      m = l >> (4'(e) + 4'd3);
      return ~{e, m[3:0]};
   endfunction : lin_to_mu

   function automatic logic [7:0] translate(input logic [7:0] b, input logic [4:0] cmh);
      logic [1:0] il;
      logic [1:0] ol;
      logic [7:0] s;
      logic [7:0] r;
      il = cmh[CCT_CMH_ICL_LSB +: 2];
      ol = cmh[CCT_CMH_OCL_LSB +: 2];
      r = b;
      // one voice/data bit per entry, so a voice law never meets a data law
      if (il == ol) begin
         r = b;
      end else if (cmh[CCT_CMH_VD_BIT]) begin
         r = b ^ data_mask(il) ^ data_mask(ol);
      end else begin
         s = b ^ variant_mask(il);
         if (il[0] != ol[0]) begin
            s = il[0] ? {s[7], lin_to_a(mu_to_lin(s))} : {s[7], lin_to_mu(a_to_lin(s))};
         end
         r = s ^ variant_mask(ol);
      end
      return r;
   endfunction : translate

   function automatic logic [7:0] force_bits(input logic [7:0] b, input logic [2:0] code);
      logic [7:0] r;
      r = b;
      if (code[CCT_QF_EN_BIT]) begin
         if (code[CCT_QF_MSB_BIT]) begin
            r[7] = code[CCT_QF_VAL_BIT];
         end else begin
            r[0] = code[CCT_QF_VAL_BIT];
         end
      end
      return r;
   endfunction : force_bits

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   logic [CCT_QFORCE_W-1:0] qforce [CCT_NUM_STREAMS];
   logic [4:0] cmh [NUM_CH];
   logic hit_q;
   logic hit_cmh;
   logic [4:0] q_idx;
   logic [CH_W-1:0] cmh_idx;
   logic [13:0] q_off;

   assign q_off = reg_addr - CCT_QFORCE_BASE;
   assign q_idx = q_off[4:0];
   assign hit_q = (reg_addr >= CCT_QFORCE_BASE) && (q_off < 14'(CCT_NUM_STREAMS));
   assign cmh_idx = reg_addr[CH_W-1:0];
   assign hit_cmh = (reg_addr >= CCT_CMH_BASE) && ((reg_addr - CCT_CMH_BASE) < 14'(NUM_CH));

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < CCT_NUM_STREAMS; i++) begin
            qforce[i] <= CCT_QFORCE_RESET;
         end
      end else if (reg_we && hit_q) begin
         qforce[q_idx] <= reg_wdata[CCT_QFORCE_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_CH; i++) begin
            cmh[i] <= CCT_CMH_RESET;
         end
      end else if (reg_we && hit_cmh) begin
         // only the low five data bits land in the entry
         cmh[cmh_idx] <= reg_wdata[4:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_re;
         if (!reg_re) begin
            reg_rdata <= reg_rdata;
         end else if (hit_q) begin
            reg_rdata <= {4'h0, qforce[q_idx]};
         end else if (hit_cmh) begin
            reg_rdata <= {11'h000, cmh[cmh_idx]};
         end else begin
            reg_rdata <= 16'h0000;
         end
      end
   end

   // ----------------------------------------
   // input side: quadrant force before the fifo
   // ----------------------------------------
   // forcing and BER reception share a stream only if software allows it
   logic [CCT_QFORCE_W-1:0] stream_q;
   logic [1:0] quad;
   logic [2:0] qcode;
   logic [7:0] forced;
   logic f_valid;
   logic f_ready;
   logic [FW-1:0] f_rd;
   logic f_pop;

   assign stream_q = qforce[in_stream];
   assign quad = quadrant_of(in_chan, in_rate);
   assign qcode = stream_q[CCT_QF_FIELD_W*quad +: CCT_QF_FIELD_W];
   assign forced = force_bits(in_byte, qcode);
   assign in_ready = f_ready;

   cct_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .s_valid(in_valid),
      .s_ready(f_ready),
      .s_data({in_out_chan, forced}),
      .m_valid(f_valid),
      .m_ready(f_pop),
      .m_data(f_rd)
   );

   // ----------------------------------------
   // output side: per-channel code translation
   // ----------------------------------------
   // same path for connection and message bytes; the entry alone decides
   assign f_pop = !out_valid || out_ready;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_valid <= 1'b0;
         out_byte <= 8'h00;
         out_chan <= '0;
      end else if (f_pop) begin
         out_valid <= f_valid;
         if (f_valid) begin
            out_byte <= translate(f_rd[7:0], cmh[f_rd[FW-1:8]]);
            out_chan <= f_rd[FW-1:8];
         end
      end
   end
endmodule : cct_top

`default_nettype wire

// >>> cct_props.sv
// port assertions for the code translate block
`timescale 1ns/1ps
`default_nettype none
module cct_props #(
   parameter int CH_W = 12,
   parameter int FIFO_DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic reg_re,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [7:0] out_byte,
   input wire logic [CH_W-1:0] out_chan
);
   logic up;
   logic [3:0] cnt;
   // words held inside, fifo plus output stage
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) up <= 1'b0;
      else up <= 1'b1;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) cnt <= 4'h0;
      else cnt <= cnt + 4'(in_valid && in_ready) - 4'(out_valid && out_ready);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_read_answered: assert property (reg_re |=> reg_rvalid) else $error("read not answered");
   a_answer_needs_read: assert property (!reg_re |=> !reg_rvalid) else $error("stray answer");
   a_rdata_upper_zero: assert property (reg_rvalid |-> reg_rdata[15:12] == 4'h0)
      else $error("upper read bits set");
   a_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("rdata moved");
   a_out_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte)
      && $stable(out_chan)) else $error("output dropped under stall");
   a_out_has_word: assert property (out_valid |-> cnt != 4'h0)
      else $error("output without input");
   a_full_refuse: assert property (up && !in_ready |-> cnt >= 4'(FIFO_DEPTH))
      else $error("refused while not full");
   a_ready_after_rst: assert property (!up ##1 up |-> in_ready) else $error("not ready");
endmodule : cct_props
bind cct_top cct_props #(.CH_W(CH_W), .FIFO_DEPTH(FIFO_DEPTH)) u_props (.clk(clk),
   .rst_b(rst_b), .reg_re(reg_re), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
   .out_byte(out_byte), .out_chan(out_chan));
`default_nettype wire

// >>> cct_sink_model.sv
// downstream consumer model, prompt, slow or stalled
`timescale 1ns/1ps
`default_nettype none
module cct_sink_model (
   input wire logic clk,
   input wire logic stall,
   input wire logic slow,
   output logic out_ready
);
   logic [1:0] ph;
   initial begin
      ph = 2'h0;
      out_ready = 1'b0;
   end
   // slow mode takes one word in four cycles
   always @(negedge clk) begin
      ph <= ph + 2'h1;
      out_ready <= !stall && (!slow || ph == 2'h0);
   end
endmodule : cct_sink_model
`default_nettype wire

// >>> cct_top_tb.sv
// self-checking bench for the code translate and bit force block
`timescale 1ns/1ps
`default_nettype none
module cct_top_tb;
   import cct_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, reg_we = 1'b0, reg_re = 1'b0, in_valid = 1'b0;
   logic stall = 1'b0, slow = 1'b0, out_ready, in_ready, out_valid, reg_rvalid;
   logic [13:0] reg_addr = 14'h0;
   logic [15:0] reg_wdata = 16'h0, reg_rdata;
   logic [7:0] in_byte = 8'h0, in_chan = 8'h0, out_byte;
   logic [4:0] in_stream = 5'h0;
   logic [1:0] in_rate = 2'h0;
   logic [11:0] in_out_chan = 12'h0, out_chan;
   int mismatches = 0, samples_checked = 0, seed = 32'h43d07c82;
   logic [19:0] dq[$];
   logic [15:0] rq[$];
   always #50 clk = ~clk;
   cct_top DUT (.clk(clk), .rst_b(rst_b), .reg_we(reg_we), .reg_re(reg_re),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .in_valid(in_valid), .in_ready(in_ready), .in_byte(in_byte),
      .in_stream(in_stream), .in_chan(in_chan), .in_rate(in_rate),
      .in_out_chan(in_out_chan), .out_valid(out_valid), .out_ready(out_ready),
      .out_byte(out_byte), .out_chan(out_chan));
   cct_sink_model u_sink (.clk(clk), .stall(stall), .slow(slow), .out_ready(out_ready));
   task automatic check(input string nm, input logic [19:0] seen, input logic [19:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic report_and_stop();
      $display("compared %0d, mismatched %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   task automatic wr(input logic [13:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_we = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_we = 1'b0;
   endtask : wr
   task automatic rd(input logic [13:0] a, input logic [15:0] e);
      @(negedge clk);
      reg_re = 1'b1;
      reg_addr = a;
      rq.push_back(e);
      @(negedge clk);
      reg_re = 1'b0;
   endtask : rd
   task automatic send(input logic [4:0] s, input logic [7:0] ch, input logic [1:0] r,
         input logic [11:0] oc, input logic [7:0] b, input logic [7:0] e);
      int n;
      @(negedge clk);
      in_valid = 1'b1;
      in_stream = s;
      in_chan = ch;
      in_rate = r;
      in_out_chan = oc;
      in_byte = b;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (in_ready !== 1'b1 && n < 200);
      if (n >= 200) begin
         mismatches++;
         report_and_stop();
      end
      dq.push_back({oc, e});
   endtask : send
   task automatic drain();
      int n;
      @(negedge clk);
      in_valid = 1'b0;
      n = 0;
      while (dq.size() + rq.size() != 0 && n < 300) begin
         @(negedge clk);
         n++;
      end
      if (n >= 300) begin
         mismatches++;
         report_and_stop();
      end
   endtask : drain
   function automatic logic [7:0] dm(input logic [1:0] c);
      return c == 2'd0 ? 8'h00 : c == 2'd1 ? CCT_EVEN_MASK : c == 2'd2 ? CCT_ODD_MASK : CCT_ALL_MASK;
   endfunction : dm
   function automatic logic [7:0] fq(input logic [2:0] c, input logic [7:0] b);
      if (!c[2]) return b;
      if (c[1]) return {c[0], b[6:0]};
      return {b[7:1], c[0]};
   endfunction : fq
   function automatic logic [7:0] vm(input logic [1:0] l);
      return l == 2'd2 ? CCT_EVEN_MASK : l == 2'd3 ? CCT_MAG_MASK : 8'h00;
   endfunction : vm
   // standard law to the other family: decode to a 16-bit magnitude, re-encode, sign kept
   function automatic logic [7:0] xlaw(input logic [7:0] b, input bit from_mu);
      int e, m, t;
      logic [6:0] x;
      x = from_mu ? ~b[6:0] : b[6:0] ^ 7'h55;
      e = x[6:4];
      m = x[3:0];
      if (from_mu) t = (((m << 3) + 132) << e) - 132;
      else if (e == 0) t = (m << 4) + 8;
      else t = ((m << 4) + 264) << (e - 1);
      e = 0;
      if (from_mu) begin
         t = t >> 3;
         for (int k = 0; k < 7; k++) begin
            if (t >= (32 << k)) e = k + 1;
         end
         m = (t >> (e < 2 ? 1 : e)) & 15;
         x = 7'(e * 16 + m) ^ 7'h55;
      end else begin
         t = t + 132;
         for (int k = 0; k < 7; k++) begin
            if (t >= (256 << k)) e = k + 1;
         end
         m = (t >> (e + 3)) & 15;
         x = ~7'(e * 16 + m);
      end
      return {b[7], x};
   endfunction : xlaw
   always @(posedge clk) begin
      if (out_valid === 1'b1 && out_ready === 1'b1)
         check("out", {out_chan, out_byte}, dq.size() ? dq.pop_front() : 20'hx);
      if (reg_rvalid === 1'b1)
         check("rdata", 20'(reg_rdata), rq.size() ? 20'(rq.pop_front()) : 20'hx);
   end
   initial begin
      logic [7:0] b, ch, ex;
      logic [1:0] il, ol;
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      rd(CCT_QFORCE_BASE + 14'd31, 16'h0);
      rd(CCT_CMH_BASE + 14'hfff, 16'h0);
      wr(CCT_QFORCE_BASE + 14'd3, 16'hffac);
      wr(CCT_QFORCE_BASE + 14'd4, 16'h0688);
      wr(CCT_CMH_BASE + 14'd100, 16'hffff);
      wr(14'h0100, 16'h1234);
      rd(CCT_QFORCE_BASE + 14'd3, 16'h0fac);
      rd(CCT_CMH_BASE + 14'd100, 16'h001f);
      rd(14'h0100, 16'h0);
      drain();
      $display("test registers done");
      for (int i = 0; i < 32; i++) wr(CCT_CMH_BASE + 14'(i), 16'(i));
      slow = 1'b1;
      // four passes over the 32 entries give each law pair several random bytes
      for (int k = 0; k < 128; k++) begin
         b = 8'($random(seed));
         il = k[3:2];
         ol = k[1:0];
         ex = k[4] ? b ^ dm(il) ^ dm(ol) : il == ol ? b : il[0] == ol[0] ?
            b ^ (il[0] ? CCT_MAG_MASK : CCT_EVEN_MASK) : xlaw(b ^ vm(il), il[0]) ^ vm(ol);
         send(5'd0, 8'(k[4:0]), 2'd0, 12'(k[4:0]), b, ex);
      end
      drain();
      $display("test translation done");
      slow = 1'b0;
      for (int r = 0; r < 4; r++)
         for (int q = 0; q < 4; q++) begin
            b = 8'($random(seed));
            ch = 8'(q * (8 << r));
            send(5'd3, ch, 2'(r), 12'd40, b, fq(3'(12'hfac >> (3 * q)), b));
            send(5'd4, ch, 2'(r), 12'd40, b, fq(3'(12'h688 >> (3 * q)), b));
            ch = ch + 8'((8 << r) - 1);
            send(5'd3, ch, 2'(r), 12'd17, b, fq(3'(12'hfac >> (3 * q)), b) ^ CCT_EVEN_MASK);
         end
      drain();
      $display("test quadrant done");
      stall = 1'b1;
      fork
         for (int k = 0; k < 8; k++) send(5'd0, 8'd0, 2'd0, 12'd40, 8'(k), 8'(k));
         begin
            repeat (20) @(negedge clk);
            check("in_ready", 20'(in_ready), 20'h0);
            stall = 1'b0;
         end
      join
      drain();
      $display("test fill done");
      report_and_stop();
   end
endmodule : cct_top_tb
`default_nettype wire
